// >>> design/dmc_pkg.sv
// shared constants, types and helpers of the dsp multiply-accumulate coprocessor
package dmc_pkg;

   // datapath widths
   localparam int ACC_W   = 40;
   localparam int WORD_W  = 32;
   localparam int HALF_W  = 16;
   localparam int FLAGS_W = 4;
   localparam int COUNT_W = 32;

   // instruction fields
   localparam int COND_MSB    = 31;
   localparam int COND_LSB    = 28;
   localparam int MAJOR_MSB   = 27;
   localparam int MAJOR_LSB   = 20;
   localparam int OPSEL_MSB   = 19;
   localparam int OPSEL_LSB   = 16;
   localparam int HALF_X_BIT  = 17;
   localparam int HALF_Y_BIT  = 16;
   localparam int MPLR_MSB    = 15;
   localparam int MPLR_LSB    = 12;
   localparam int ZERO_MSB    = 11;
   localparam int ZERO_LSB    = 8;
   localparam int ACCSEL_MSB  = 7;
   localparam int ACCSEL_LSB  = 5;
   localparam int MARK_BIT    = 4;
   localparam int MCAND_MSB   = 3;
   localparam int MCAND_LSB   = 0;

   localparam logic [7:0] MAC_MAJOR  = 8'hE2;
   localparam logic [3:0] ZERO_FIELD = 4'h0;

   // operation-select codes
   localparam logic [3:0] OP_WORD_MAC          = 4'h0;
   localparam logic [3:0] OP_DUAL_HALF_MAC     = 4'h8;
   localparam logic [3:0] OP_HALF_MAC_LOW_LOW  = 4'hC;
   localparam logic [3:0] OP_HALF_MAC_LOW_HIGH = 4'hD;
   localparam logic [3:0] OP_HALF_MAC_HIGH_LOW = 4'hE;
   localparam logic [3:0] OP_HALF_MAC_HIGH_HIGH = 4'hF;

   typedef enum logic [1:0] {
      MK_NONE = 2'b00,
      MK_WORD = 2'b01,
      MK_DUAL = 2'b10,
      MK_HALF = 2'b11
   } dmc_mac_kind_t;

   // register map, byte addresses
   localparam int ADDR_W = 5;
   localparam logic [4:0] REG_CTRL      = 5'h00;
   localparam logic [4:0] REG_STATUS    = 5'h04;
   localparam logic [4:0] REG_ACC_LO    = 5'h08;
   localparam logic [4:0] REG_ACC_HI    = 5'h0C;
   localparam logic [4:0] REG_MAC_COUNT = 5'h10;

   // field positions
   localparam int CTRL_ACCESS_EN_BIT = 0;
   localparam int STAT_UNDEF_BIT     = 0;
   localparam int STAT_DECODE_BIT    = 1;
   localparam int ACC_HI_W           = 8;

   // reset values
   localparam logic [39:0] ACC_RST       = 40'h00_0000_0000;
   localparam logic        ACCESS_EN_RST = 1'b0;
   localparam logic [31:0] WORD_RST      = 32'h0000_0000;
   localparam logic [31:0] COUNT_RST     = 32'h0000_0000;

   // condition check against n z c v flags
   function automatic logic dmc_cond_pass(input logic [3:0] cond, input logic [3:0] nzcv);
      logic n;
      logic z;
      logic c;
      logic v;
      n = nzcv[3];
      z = nzcv[2];
      c = nzcv[1];
      v = nzcv[0];
      case (cond)
         4'h0: dmc_cond_pass = z;
         4'h1: dmc_cond_pass = ~z;
         4'h2: dmc_cond_pass = c;
         4'h3: dmc_cond_pass = ~c;
         4'h4: dmc_cond_pass = n;
         4'h5: dmc_cond_pass = ~n;
         4'h6: dmc_cond_pass = v;
         4'h7: dmc_cond_pass = ~v;
         4'h8: dmc_cond_pass = c & ~z;
         4'h9: dmc_cond_pass = ~c | z;
         4'hA: dmc_cond_pass = (n == v);
         4'hB: dmc_cond_pass = (n != v);
         4'hC: dmc_cond_pass = ~z & (n == v);
         4'hD: dmc_cond_pass = z | (n != v);
         default: dmc_cond_pass = 1'b1;
      endcase
   endfunction : dmc_cond_pass

   // byte-enable merge of a bus write into a stored word
   function automatic logic [31:0] dmc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      dmc_merge = r;
   endfunction : dmc_merge

endpackage : dmc_pkg

// >>> design/dmc_mac_unit.sv
// signed product unit: forms the 40-bit addend for each multiply-accumulate kind
module dmc_mac_unit
   import dmc_pkg::*;
(
   // operation
   input  wire dmc_pkg::dmc_mac_kind_t kind,
   input  wire logic                   sel_x,
   input  wire logic                   sel_y,
   // operands
   input  wire logic [31:0]            multiplier_reg,
   input  wire logic [31:0]            multiplicand_reg,
   // result
   output logic      [39:0]            addend
);
   import dmc_pkg::*;

   logic signed [63:0] word_prod;
   logic signed [31:0] low_prod;
   logic signed [31:0] high_prod;
   logic signed [31:0] half_prod;
   logic signed [15:0] half_mcand;
   logic signed [15:0] half_mplr;
   logic        [39:0] dual_sum;

   // every operand is two's complement, no unsigned form
   assign word_prod  = $signed(multiplier_reg) * $signed(multiplicand_reg);
   assign low_prod   = $signed(multiplier_reg[15:0]) * $signed(multiplicand_reg[15:0]);
   assign high_prod  = $signed(multiplier_reg[31:16]) * $signed(multiplicand_reg[31:16]);
   assign half_mcand = sel_x ? multiplicand_reg[31:16] : multiplicand_reg[15:0];
   assign half_mplr  = sel_y ? multiplier_reg[31:16] : multiplier_reg[15:0];
   assign half_prod  = half_mcand * half_mplr;
   assign dual_sum   = {{8{low_prod[31]}}, low_prod} + {{8{high_prod[31]}}, high_prod};

   always_comb begin
      case (kind)
         MK_WORD: addend = word_prod[39:0];
         MK_DUAL: addend = dual_sum;
         MK_HALF: addend = {{8{half_prod[31]}}, half_prod};
         default: addend = ACC_RST;
      endcase
   end

endmodule : dmc_mac_unit

// >>> design/dmc_mac_top.sv
// dsp multiply-accumulate coprocessor: decoder, accumulator and avalon register slave
// Notes on behaviour
// - one 40-bit accumulator is every destination
// - enabled coprocessor runs in any processor mode
// - disabled coprocessor refuses, raises undefined exception
// - access bit written only when privileged
// - recognise major e2, zero bits, marker bit
// - register and selector fields at fixed bits
// - opcode 0 word, 8 dual half
// - opcodes c to f select halves
// - update only when condition passes
// - signed 32x32 product added to accumulator
// - all operands signed, no unsigned form
// - dual: low halves and high halves multiplied
// - both products sign-extended, summed into accumulator
// - accumulator readable and writable by core
// - selector one picks top half
// - one half product added, flags untouched
// - accumulator moves use two words
module dmc_mac_top
   import dmc_pkg::*;
(
   // clock and reset
   input  wire logic                       CORE_CLK,
   input  wire logic                       RST,
   // instruction issue from the core
   input  wire logic                       INSTR_VALID,
   input  wire logic [31:0]                INSTR_WORD,
   input  wire logic [31:0]                MULTIPLIER_VAL,
   input  wire logic [31:0]                MULTIPLICAND_VAL,
   input  wire logic [dmc_pkg::FLAGS_W-1:0] COND_FLAGS,
   input  wire logic                       PRIV_MODE,
   // instruction answer
   output logic                            INSTR_DONE,
   output logic                            INSTR_UNDEF,
   output logic                            INSTR_EXECUTED,
   output logic [dmc_pkg::ACC_W-1:0]       ACC_VALUE,
   // avalon-mm slave
   input  wire logic [dmc_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input  wire logic                       AVS_READ,
   input  wire logic                       AVS_WRITE,
   input  wire logic [31:0]                AVS_WRITEDATA,
   input  wire logic [3:0]                 AVS_BYTEENABLE,
   output logic [31:0]                     AVS_READDATA,
   output logic                            AVS_WAITREQUEST
);
   import dmc_pkg::*;

   // architectural state
   logic [39:0]   mac_accumulator_r;
   logic [39:0]   mac_accumulator_nxt;
   logic          access_en_r;
   logic [31:0]   lo_stage_r;
   logic          undef_flag_r;
   logic          decode_flag_r;
   logic [31:0]   mac_count_r;

   // answer flip-flops
   logic          done_r;
   logic          undef_r;
   logic          exec_r;
   logic [31:0]   rdata_r;
   logic          ack_r;

   // decode
   logic          is_mac_format;
   logic [3:0]    op_sel;
   logic [3:0]    cond_field;
   logic [3:0]    mplr_idx;
   logic [3:0]    mcand_idx;
   logic [2:0]    acc_sel;
   dmc_mac_kind_t kind;
   logic          cond_ok;
   logic          instr_undef;
   logic          instr_exec;
   logic          instr_miss;
   logic [39:0]   addend;

   // bus
   logic          bus_req;
   logic          bus_commit;
   logic          bus_first;
   logic          wr_ctrl;
   logic          wr_status;
   logic          wr_acc_lo;
   logic          wr_acc_hi;
   logic          acc_reg_hit;
   logic          bus_refused;
   logic          acc_load;
   logic [39:0]   acc_load_val;
   logic [39:0]   acc_base;
   logic [31:0]   rdata_nxt;

   // ------------------------------------------------------------------
   // instruction decode
   // ------------------------------------------------------------------
   assign is_mac_format = (INSTR_WORD[MAJOR_MSB:MAJOR_LSB] == MAC_MAJOR)
                        && (INSTR_WORD[ZERO_MSB:ZERO_LSB] == ZERO_FIELD)
                        && INSTR_WORD[MARK_BIT];
   assign cond_field = INSTR_WORD[COND_MSB:COND_LSB];
   assign op_sel     = INSTR_WORD[OPSEL_MSB:OPSEL_LSB];
   assign mplr_idx   = INSTR_WORD[MPLR_MSB:MPLR_LSB];
   assign acc_sel    = INSTR_WORD[ACCSEL_MSB:ACCSEL_LSB];
   assign mcand_idx  = INSTR_WORD[MCAND_MSB:MCAND_LSB];

   // operand values arrive already read from the core registers named by the indices;
   // the indices and the accumulator selector steer nothing here, as only one accumulator exists
   always_comb begin
      kind = MK_NONE;
      if (is_mac_format) begin
         case (op_sel)
            OP_WORD_MAC:           kind = MK_WORD;
            OP_DUAL_HALF_MAC:      kind = MK_DUAL;
            OP_HALF_MAC_LOW_LOW,
            OP_HALF_MAC_LOW_HIGH,
            OP_HALF_MAC_HIGH_LOW,
            OP_HALF_MAC_HIGH_HIGH: kind = MK_HALF;
            default:               kind = MK_NONE;
         endcase
      end
   end

   assign cond_ok = dmc_cond_pass(cond_field, COND_FLAGS);

   // privilege plays no part in instruction acceptance
   assign instr_undef = INSTR_VALID && !access_en_r;
   assign instr_exec  = INSTR_VALID && access_en_r && (kind != MK_NONE) && cond_ok;
   assign instr_miss  = INSTR_VALID && access_en_r && (kind == MK_NONE);

   dmc_mac_unit u_mac_unit (
      .kind             (kind),
      .sel_x            (INSTR_WORD[HALF_X_BIT]),
      .sel_y            (INSTR_WORD[HALF_Y_BIT]),
      .multiplier_reg   (MULTIPLIER_VAL),
      .multiplicand_reg (MULTIPLICAND_VAL),
      .addend           (addend)
   );

   // ------------------------------------------------------------------
   // avalon slave: every access waits one cycle, then completes
   // ------------------------------------------------------------------
   assign bus_req         = AVS_READ || AVS_WRITE;
   assign AVS_WAITREQUEST = bus_req && !ack_r;
   assign bus_first       = bus_req && !ack_r;
   assign bus_commit      = bus_req && ack_r;

   assign acc_reg_hit = (AVS_ADDRESS == REG_ACC_LO) || (AVS_ADDRESS == REG_ACC_HI);
   // accumulator moves are coprocessor accesses and obey the enable bit
   assign bus_refused = acc_reg_hit && !access_en_r;

   assign wr_ctrl   = bus_commit && AVS_WRITE && (AVS_ADDRESS == REG_CTRL);
   assign wr_status = bus_commit && AVS_WRITE && (AVS_ADDRESS == REG_STATUS);
   assign wr_acc_lo = bus_commit && AVS_WRITE && (AVS_ADDRESS == REG_ACC_LO) && access_en_r;
   assign wr_acc_hi = bus_commit && AVS_WRITE && (AVS_ADDRESS == REG_ACC_HI) && access_en_r;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_first;
      end
   end

   always_comb begin
      rdata_nxt = WORD_RST;
      case (AVS_ADDRESS)
         REG_CTRL:      rdata_nxt[CTRL_ACCESS_EN_BIT] = access_en_r;
         REG_STATUS: begin
            rdata_nxt[STAT_UNDEF_BIT]  = undef_flag_r;
            rdata_nxt[STAT_DECODE_BIT] = decode_flag_r;
         end
         REG_ACC_LO:    rdata_nxt = access_en_r ? mac_accumulator_r[31:0] : WORD_RST;
         REG_ACC_HI:    rdata_nxt[ACC_HI_W-1:0] = access_en_r ? mac_accumulator_r[39:32] : 8'h00;
         REG_MAC_COUNT: rdata_nxt = mac_count_r;
         default:       rdata_nxt = WORD_RST;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rdata_r <= WORD_RST;
      end else if (bus_first && AVS_READ) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign AVS_READDATA = rdata_r;

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         access_en_r <= ACCESS_EN_RST;
      end else if (wr_ctrl && PRIV_MODE && AVS_BYTEENABLE[0]) begin
         access_en_r <= AVS_WRITEDATA[CTRL_ACCESS_EN_BIT];
      end
   end

   // ------------------------------------------------------------------
   // sticky status, write one to clear, a new event beats the clear
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         undef_flag_r <= 1'b0;
      end else if (instr_undef || (bus_commit && bus_refused)) begin
         undef_flag_r <= 1'b1;
      end else if (wr_status && AVS_BYTEENABLE[0] && AVS_WRITEDATA[STAT_UNDEF_BIT]) begin
         undef_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         decode_flag_r <= 1'b0;
      end else if (instr_miss) begin
         decode_flag_r <= 1'b1;
      end else if (wr_status && AVS_BYTEENABLE[0] && AVS_WRITEDATA[STAT_DECODE_BIT]) begin
         decode_flag_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // accumulator: low word staged, high byte write loads all 40 bits
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         lo_stage_r <= WORD_RST;
      end else if (wr_acc_lo) begin
         lo_stage_r <= dmc_merge(lo_stage_r, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
   end

   assign acc_load     = wr_acc_hi && AVS_BYTEENABLE[0];
   assign acc_load_val = {AVS_WRITEDATA[ACC_HI_W-1:0], lo_stage_r};
   // a load and a multiply in one cycle: the multiply adds onto the loaded value
   assign acc_base     = acc_load ? acc_load_val : mac_accumulator_r;

   always_comb begin
      mac_accumulator_nxt = acc_base;
      if (instr_exec) begin
         mac_accumulator_nxt = acc_base + addend;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mac_accumulator_r <= ACC_RST;
      end else begin
         mac_accumulator_r <= mac_accumulator_nxt;
      end
   end

   assign ACC_VALUE = mac_accumulator_r;

   // ------------------------------------------------------------------
   // executed-operation counter
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mac_count_r <= COUNT_RST;
      end else if (instr_exec) begin
         mac_count_r <= mac_count_r + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------------
   // instruction answer pulses, one cycle after issue
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         done_r  <= 1'b0;
         undef_r <= 1'b0;
         exec_r  <= 1'b0;
      end else begin
         done_r  <= INSTR_VALID && access_en_r;
         undef_r <= instr_undef;
         exec_r  <= instr_exec;
      end
   end

   // no condition flag output exists: the core flags are never written
   assign INSTR_DONE     = done_r;
   assign INSTR_UNDEF    = undef_r;
   assign INSTR_EXECUTED = exec_r;

endmodule : dmc_mac_top

// >>> dv/dmc_core_model.sv
// core model: issues coprocessor instructions with operands and condition flags
module dmc_core_model
   import dmc_pkg::*;
(
   // clock
   input  wire logic                         clk,
   // instruction issue
   output logic                              instr_valid,
   output logic [31:0]                       instr_word,
   output logic [31:0]                       mplr_val,
   output logic [31:0]                       mcand_val,
   output logic [dmc_pkg::FLAGS_W-1:0]       flags
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      instr_valid = 1'b0;
      instr_word  = 32'h0000_0000;
      mplr_val    = 32'h0000_0000;
      mcand_val   = 32'h0000_0000;
      flags       = 4'h0;
   end

   // one issue cycle; calls may follow each other for back-to-back issue
   task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic [3:0] f);
      logic [31:0] v;
      v = w;
      v[7:5] = 3'h0;
      if (v[27:20] == MAC_MAJOR && !(v[19:16] inside {4'h0, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF})) begin
         v[19:16] = OP_WORD_MAC;
      end
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= v;
      mplr_val    <= a;
      mcand_val   <= b;
      flags       <= f;
   endtask : issue

   // released operands no longer show their last value
   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
      mplr_val    <= ~mplr_val;
      mcand_val   <= ~mcand_val;
      flags       <= ~flags;
   endtask : idle

endmodule : dmc_core_model

// >>> dv/dmc_mac_properties.sv
// concurrent checks on the multiply-accumulate coprocessor ports
module dmc_mac_properties
   import dmc_pkg::*;
(
   // clock and reset
   input  wire logic                         CORE_CLK,
   input  wire logic                         RST,
   // instruction issue and answer
   input  wire logic                         INSTR_VALID,
   input  wire logic [31:0]                  INSTR_WORD,
   input  wire logic [31:0]                  MULTIPLIER_VAL,
   input  wire logic [31:0]                  MULTIPLICAND_VAL,
   input  wire logic [dmc_pkg::FLAGS_W-1:0]  COND_FLAGS,
   input  wire logic                         INSTR_DONE,
   input  wire logic                         INSTR_UNDEF,
   input  wire logic                         INSTR_EXECUTED,
   input  wire logic [dmc_pkg::ACC_W-1:0]    ACC_VALUE,
   // bus
   input  wire logic                         AVS_WRITE
);
   logic               is_mac;
   logic [3:0]         op;
   logic signed [15:0] hx;
   logic signed [15:0] hy;
   logic signed [63:0] p_word;
   logic signed [63:0] p_dual;
   logic signed [63:0] p_half;

   assign is_mac = INSTR_WORD[27:20] == MAC_MAJOR && INSTR_WORD[11:8] == ZERO_FIELD && INSTR_WORD[4];
   assign op     = INSTR_WORD[19:16];
   assign hx     = INSTR_WORD[17] ? MULTIPLICAND_VAL[31:16] : MULTIPLICAND_VAL[15:0];
   assign hy     = INSTR_WORD[16] ? MULTIPLIER_VAL[31:16] : MULTIPLIER_VAL[15:0];
   assign p_word = $signed(MULTIPLIER_VAL) * $signed(MULTIPLICAND_VAL);
   assign p_dual = $signed(MULTIPLIER_VAL[15:0]) * $signed(MULTIPLICAND_VAL[15:0])
                 + $signed(MULTIPLIER_VAL[31:16]) * $signed(MULTIPLICAND_VAL[31:16]);
   assign p_half = hx * hy;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   // an executed mac adds exactly its own addend, wrapping at 40 bits
   property p_sum(hit, logic [39:0] add);
      INSTR_VALID && hit && !AVS_WRITE ##1 INSTR_EXECUTED |-> ACC_VALUE == $past(ACC_VALUE) + $past(add);
   endproperty

   word_sum_a: assert property (p_sum(is_mac && op == OP_WORD_MAC, p_word[39:0]))
      else $error("word mac sum mismatch");
   dual_sum_a: assert property (p_sum(is_mac && op == OP_DUAL_HALF_MAC, p_dual[39:0]))
      else $error("dual half mac sum mismatch");
   half_sum_a: assert property (p_sum(is_mac && op[3:2] == 2'b11, p_half[39:0]))
      else $error("half mac sum mismatch");
   one_answer_a: assert property (INSTR_VALID |=> INSTR_DONE ^ INSTR_UNDEF)
      else $error("issue not answered by exactly one of done and undef");
   quiet_idle_a: assert property (!INSTR_VALID |=> !INSTR_DONE && !INSTR_UNDEF && !INSTR_EXECUTED)
      else $error("answer pulse without issue");
   undef_inert_a: assert property (INSTR_VALID ##1 INSTR_UNDEF |-> !INSTR_EXECUTED && $stable(ACC_VALUE))
      else $error("refused instruction changed state");
   cond_fail_a: assert property (INSTR_VALID && INSTR_WORD[31:28] == 4'h0 && !COND_FLAGS[2] && !AVS_WRITE
      |=> !INSTR_EXECUTED && $stable(ACC_VALUE)) else $error("failed condition still executed");
   decode_miss_a: assert property (INSTR_VALID && !is_mac |=> !INSTR_EXECUTED)
      else $error("non mac word executed");
   acc_hold_a: assert property (!INSTR_VALID && !AVS_WRITE |=> $stable(ACC_VALUE))
      else $error("accumulator moved without cause");

   cov_word: cover property (INSTR_VALID && is_mac && op == OP_WORD_MAC ##1 INSTR_EXECUTED);
   cov_dual: cover property (INSTR_VALID && is_mac && op == OP_DUAL_HALF_MAC ##1 INSTR_EXECUTED);
   cov_undef: cover property (INSTR_VALID ##1 INSTR_UNDEF);

endmodule : dmc_mac_properties

bind dmc_mac_top dmc_mac_properties i_props (
   .CORE_CLK, .RST, .INSTR_VALID, .INSTR_WORD, .MULTIPLIER_VAL, .MULTIPLICAND_VAL, .COND_FLAGS,
   .INSTR_DONE, .INSTR_UNDEF, .INSTR_EXECUTED, .ACC_VALUE, .AVS_WRITE
);

// >>> dv/dsp_mac_coprocessor_tb.sv
// self-checking testbench of the multiply-accumulate coprocessor
module dsp_mac_coprocessor_tb;
   import dmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk;
   logic        rst;
   logic        priv_mode;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        instr_valid;
   logic [31:0] instr_word;
   logic [31:0] mplr_val;
   logic [31:0] mcand_val;
   logic [3:0]  flags;
   logic        instr_done;
   logic        instr_undef;
   logic        instr_executed;
   logic [39:0] acc_value;
   logic [39:0] exp_acc;
   logic [3:0]  ops [6] = '{4'h0, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
   int          n_errors;
   int          compares;

   dmc_mac_top i_dut (
      .CORE_CLK(core_clk), .RST(rst), .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
      .MULTIPLIER_VAL(mplr_val), .MULTIPLICAND_VAL(mcand_val), .COND_FLAGS(flags), .PRIV_MODE(priv_mode),
      .INSTR_DONE(instr_done), .INSTR_UNDEF(instr_undef), .INSTR_EXECUTED(instr_executed), .ACC_VALUE(acc_value),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest)
   );

   dmc_core_model i_core (
      .clk(core_clk), .instr_valid(instr_valid), .instr_word(instr_word), .mplr_val(mplr_val),
      .mcand_val(mcand_val), .flags(flags)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic final_report();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one avalon transfer: request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address   <= a;
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         final_report();
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk({8'h00, q}, {8'h00, e});
   endtask : rd_chk

   function automatic logic [31:0] mw(input logic [3:0] cnd, input logic [3:0] op);
      return {cnd, MAC_MAJOR, op, 4'h3, ZERO_FIELD, 3'h0, 1'b1, 4'h5};
   endfunction : mw

   // a is the multiplier value, b the multiplicand value
   function automatic logic [39:0] mac_add(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
      logic signed [63:0] p;
      logic signed [15:0] x;
      logic signed [15:0] y;
      x = op[1] ? b[31:16] : b[15:0];
      y = op[0] ? a[31:16] : a[15:0];
      if (op == OP_WORD_MAC) p = $signed(a) * $signed(b);
      else if (op == OP_DUAL_HALF_MAC) p = $signed(a[15:0]) * $signed(b[15:0]) + $signed(a[31:16]) * $signed(b[31:16]);
      else p = x * y;
      return p[39:0];
   endfunction : mac_add

   // issue one word, then compare {done, undef, executed} and the accumulator
   task automatic mac(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic [3:0] f,
                      input logic [2:0] ep);
      i_core.issue(w, a, b, f);
      i_core.idle();
      @(negedge core_clk);
      if (ep[0]) exp_acc = exp_acc + mac_add(w[19:16], a, b);
      chk({37'h0, instr_done, instr_undef, instr_executed}, {37'h0, ep});
      chk(acc_value, exp_acc);
   endtask : mac

   initial begin
      rst = 1'b1;
      priv_mode = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      exp_acc = 40'h00_0000_0000;
      n_errors = 0;
      compares = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(REG_CTRL, 32'h0000_0000);
      mac(mw(4'hE, OP_WORD_MAC), 32'h0000_0005, 32'h0000_0007, 4'h0, 3'b010);
      rd_chk(REG_STATUS, 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0001);
      rd_chk(REG_CTRL, 32'h0000_0000);
      priv_mode <= 1'b1;
      wr(REG_CTRL, 32'h0000_0001);
      rd_chk(REG_CTRL, 32'h0000_0001);
      priv_mode <= 1'b0;
      wr(REG_STATUS, 32'h0000_0003);
      rd_chk(REG_STATUS, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         mac(mw(4'hE, ops[i]), 32'h8001_7FFF, 32'hFFFE_8000, 4'h0, 3'b101);
      end
      mac(mw(4'hE, OP_WORD_MAC), 32'h8000_0000, 32'hFFFF_FFFD, 4'h0, 3'b101);
      mac(mw(4'h0, OP_WORD_MAC), 32'h0000_1234, 32'h0000_0100, 4'h0, 3'b100);
      mac(mw(4'h0, OP_HALF_MAC_HIGH_LOW), 32'h0000_1234, 32'hFFFF_0100, 4'h4, 3'b101);
      mac(32'hEE20_3F35, 32'h0000_0003, 32'h0000_0003, 4'h0, 3'b100);
      mac(32'hEE20_3025, 32'h0000_0003, 32'h0000_0003, 4'h0, 3'b100);
      mac(32'hEE30_3035, 32'h0000_0003, 32'h0000_0003, 4'h0, 3'b100);
      rd_chk(REG_STATUS, 32'h0000_0002);
      i_core.issue(mw(4'hE, OP_DUAL_HALF_MAC), 32'h7FFF_8000, 32'h7FFF_8000, 4'h0);
      i_core.issue(mw(4'hE, OP_HALF_MAC_HIGH_HIGH), 32'h8000_0001, 32'h8000_0001, 4'h0);
      i_core.idle();
      @(negedge core_clk);
      exp_acc = exp_acc + mac_add(4'h8, 32'h7FFF_8000, 32'h7FFF_8000) + mac_add(4'hF, 32'h8000_0001, 32'h8000_0001);
      chk(acc_value, exp_acc);
      wr(REG_ACC_LO, 32'hFFFF_FFFF);
      wr(REG_ACC_HI, 32'h0000_00FF);
      exp_acc = 40'hFF_FFFF_FFFF;
      rd_chk(REG_ACC_HI, 32'h0000_00FF);
      mac(mw(4'hE, OP_WORD_MAC), 32'h0000_0001, 32'h0000_0002, 4'h0, 3'b101);
      rd_chk(REG_ACC_LO, 32'h0000_0001);
      rd_chk(REG_MAC_COUNT, 32'h0000_000B);
      rd_chk(5'h14, 32'h0000_0000);
      priv_mode <= 1'b1;
      wr(REG_CTRL, 32'h0000_0000);
      rd_chk(REG_ACC_LO, 32'h0000_0000);
      mac(mw(4'hE, OP_DUAL_HALF_MAC), 32'h0001_0001, 32'h0001_0001, 4'h0, 3'b010);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      final_report();
   end

endmodule : dsp_mac_coprocessor_tb
